//--- ppp_cfg.svh
`ifndef PPP_CFG_SVH
`define PPP_CFG_SVH
// Action select codes
`define ACT_ADDR        2'h0
`define ACT_DATA        2'h1
`define ACT_CMD         2'h2
`define ACT_IDLE        2'h3
// Command bytes
`define CMD_NOP         8'h00
`define CMD_CHIP_ERASE  8'h80
`define CMD_WR_FUSE     8'h40
`define CMD_WR_LOCK     8'h20
`define CMD_WR_FLASH    8'h10
`define CMD_WR_EEPROM   8'h11
`define CMD_RD_SIG      8'h08
`define CMD_RD_FUSE     8'h04
`define CMD_RD_FLASH    8'h02
`define CMD_RD_EEPROM   8'h03
// Memory geometry
`define FLASH_AW        13
`define PAGE_WORD_BITS  4
`define EE_AW           8
`define EE_PAGE_BITS    2
// Reset values
`define ERASED_BYTE     8'hFF
`define LOCK_RESET      8'hFF
`define FUSE_LO_RESET   8'hFF
`define FUSE_HI_RESET   8'hFF
`define FUSE_EX_RESET   8'hFF
`define KEEP_EE_BIT     3
// Timing
`define CLK_NS          25
`define ENTRY_HOLD_US   10
`define ENTRY_HOLD_CYC  ((`ENTRY_HOLD_US * 1000 + `CLK_NS - 1) / `CLK_NS)
// Identification bytes; values are arbitrary
`define SIG_BYTE_0      8'hA5
`define SIG_BYTE_1      8'h5A
`define SIG_BYTE_2      8'h3C
`define CAL_BYTE        8'h80
`endif

//--- ppp_pkg.sv
package ppp_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ERASE,
      ST_PROG,
      ST_FUSE
   } op_state_t;
endpackage

//--- ppp_fifo.sv
`timescale 1ns/1ps
// Small FIFO with valid/ready on both sides
module ppp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clock_in,
   input  wire logic             reset_in,
   input  wire logic             enable_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   output logic      [WIDTH-1:0] rd_data_out,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // Handshake
   assign wr_ready_out = (cnt_q != (AW+1)'(DEPTH));
   assign rd_valid_out = (cnt_q != '0);
   assign push = wr_valid_in && wr_ready_out && enable_in;
   assign pop  = rd_valid_out && rd_ready_in && enable_in;
   assign rd_data_out = mem_q[rp_q];

   // Storage
   always_ff @(posedge clock_in) begin
      if (push) begin
         mem_q[wp_q] <= wr_data_in;
      end
   end

   // Pointers and count
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

//--- ppp_port.sv
`timescale 1ns/1ps
`include "ppp_cfg.svh"
module ppp_port #(
   parameter int FLASH_AW   = `FLASH_AW,
   parameter int PAGE_BITS  = `PAGE_WORD_BITS,
   parameter int EE_AW      = `EE_AW,
   parameter int EE_PBITS   = `EE_PAGE_BITS,
   parameter int FIFO_DEPTH = 8,
   parameter int OP_CYCLES  = 64
) (
   input  wire logic       clock_in,
   input  wire logic       reset_in,
   input  wire logic       enable_in,
   input  wire logic       hv_reset_in,
   input  wire logic       load_strobe_clock_in,
   input  wire logic       write_strobe_n_in,
   input  wire logic       output_enable_n_in,
   input  wire logic       byte_select_lo_in,
   input  wire logic       action_sel_0_in,
   input  wire logic       action_sel_1_in,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe_n_out,
   output logic            ready_busy_n_out,
   output logic            prog_mode_out
);
   localparam int FW = FLASH_AW;
   localparam int FWORDS = 1 << FW;
   localparam int EBYTES = 1 << EE_AW;
   localparam int PWORDS = 1 << PAGE_BITS;

   // Two-flop synchronisers for all pins, idle strobe levels on reset
   logic [14:0] s1_q;
   logic [14:0] s2_q;
   logic [14:0] pins;
   assign pins = {hv_reset_in, load_strobe_clock_in, write_strobe_n_in,
                  output_enable_n_in, byte_select_lo_in, action_sel_0_in,
                  action_sel_1_in, data_in};
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         s1_q <= 15'h1800;
         s2_q <= 15'h1800;
      end else if (enable_in) begin
         s1_q <= pins;
         s2_q <= s1_q;
      end
   end
   logic       hv;
   logic       ldclk;
   logic       wr_n;
   logic       oe_n;
   logic       bsel;
   logic       asel0;
   logic       asel1;
   logic [7:0] dat;
   assign {hv, ldclk, wr_n, oe_n, bsel, asel0, asel1, dat} = s2_q;

   // Previous levels for edge detection
   logic ldclk_q;
   logic wr_n_q;
   logic bsel_q;
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         ldclk_q <= 1'b0;
         wr_n_q  <= 1'b1;
         bsel_q  <= 1'b0;
      end else if (enable_in) begin
         ldclk_q <= ldclk;
         wr_n_q  <= wr_n;
         bsel_q  <= bsel;
      end
   end
   logic clk_rise;
   logic wr_fall;
   logic pl_rise;
   assign clk_rise = ldclk && !ldclk_q;
   assign wr_fall  = !wr_n && wr_n_q;
   assign pl_rise  = bsel && !bsel_q &&
                     {asel1, asel0} == `ACT_IDLE;

   // Entry: pattern held low while high voltage applied
   logic [9:0] entry_cnt_q;
   logic       mode_q;
   logic       pat_ok;
   assign pat_ok = !wr_n && !bsel && !asel0 && !asel1;
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         entry_cnt_q <= 10'h000;
         mode_q      <= 1'b0;
      end else if (enable_in) begin
         if (!hv) begin
            entry_cnt_q <= 10'h000;
            mode_q      <= 1'b0;
         end else if (!mode_q) begin
            if (!pat_ok) begin
               entry_cnt_q <= 10'h000;
            end else if (entry_cnt_q == 10'(`ENTRY_HOLD_CYC - 1)) begin
               mode_q <= 1'b1;
            end else begin
               entry_cnt_q <= entry_cnt_q + 10'h001;
            end
         end
      end
   end
   assign prog_mode_out = mode_q;

   // Command, address and data latches
   logic [7:0] cmd_q;
   logic [7:0] addr_lo_q;
   logic [7:0] addr_hi_q;
   logic [7:0] data_lo_q;
   logic [7:0] data_hi_q;
   logic       busy;
   logic       act;
   assign act = mode_q && clk_rise && !busy;
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         cmd_q     <= `CMD_NOP;
         addr_lo_q <= 8'h00;
         addr_hi_q <= 8'h00;
         data_lo_q <= 8'h00;
         data_hi_q <= 8'h00;
      end else if (enable_in) begin
         if (!mode_q) begin
            cmd_q <= `CMD_NOP;
         end else if (act) begin
            unique case ({asel1, asel0})
               `ACT_ADDR: begin
                  if (bsel) addr_hi_q <= dat;
                  else addr_lo_q <= dat;
               end
               `ACT_DATA: begin
                  if (bsel) data_hi_q <= dat;
                  else data_lo_q <= dat;
               end
               `ACT_CMD:  cmd_q <= dat;
               `ACT_IDLE: ;
            endcase
         end
      end
   end

   // Page buffer fills through a FIFO of words
   logic [PAGE_BITS+15:0] fifo_wd;
   logic [PAGE_BITS+15:0] fifo_rd;
   logic                  fifo_wv;
   logic                  fifo_wr;
   logic                  fifo_rv;
   logic                  fifo_rr;
   logic                  wr_flash;
   logic                  wr_ee;
   assign wr_flash = cmd_q == `CMD_WR_FLASH;
   assign wr_ee    = cmd_q == `CMD_WR_EEPROM;
   assign fifo_wd  = {addr_lo_q[PAGE_BITS-1:0], data_hi_q, data_lo_q};
   assign fifo_wv  = mode_q && pl_rise && (wr_flash || wr_ee);
   assign fifo_rr  = 1'b1;
   ppp_fifo #(.WIDTH(PAGE_BITS + 16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock_in     (clock_in),
      .reset_in     (reset_in),
      .enable_in    (enable_in),
      .wr_data_in   (fifo_wd),
      .wr_valid_in  (fifo_wv),
      .wr_ready_out (fifo_wr),
      .rd_data_out  (fifo_rd),
      .rd_valid_out (fifo_rv),
      .rd_ready_in  (fifo_rr)
   );

   // Memories
   logic [15:0] flash_q [FWORDS];
   logic [7:0]  ee_q    [EBYTES];
   logic [15:0] pbuf_q  [PWORDS];
   logic [7:0]  lock_q;
   logic [7:0]  fuse_lo_q;
   logic [7:0]  fuse_hi_q;
   logic [7:0]  fuse_ex_q;

   // Self-timed operation sequencer
   ppp_pkg::op_state_t st_q;
   logic [15:0] cnt_q;
   logic [FW:0] er_idx_q;
   logic [7:0]  op_cmd_q;
   logic        bsel2;
   assign bsel2 = asel1;
   assign busy = st_q != ppp_pkg::ST_IDLE;
   assign ready_busy_n_out = !busy;

   // Word address from both address bytes
   function automatic logic [FW-1:0] word_addr(input logic [7:0] hi,
                                               input logic [7:0] lo);
      word_addr = FW'({hi, lo});
   endfunction

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         st_q     <= ppp_pkg::ST_IDLE;
         cnt_q    <= 16'h0000;
         er_idx_q <= '0;
         op_cmd_q <= `CMD_NOP;
      end else if (enable_in) begin
         unique case (st_q)
            ppp_pkg::ST_IDLE: begin
               cnt_q    <= 16'h0000;
               er_idx_q <= '0;
               if (mode_q && wr_fall) begin
                  op_cmd_q <= cmd_q;
                  if (cmd_q == `CMD_CHIP_ERASE) begin
                     st_q <= ppp_pkg::ST_ERASE;
                  end else if (wr_flash || wr_ee) begin
                     st_q <= ppp_pkg::ST_PROG;
                  end else if (cmd_q == `CMD_WR_FUSE ||
                               cmd_q == `CMD_WR_LOCK) begin
                     st_q <= ppp_pkg::ST_FUSE;
                  end
               end
            end
            ppp_pkg::ST_ERASE: begin
               if (er_idx_q == (FW+1)'(FWORDS)) begin
                  st_q <= ppp_pkg::ST_IDLE;
               end else begin
                  er_idx_q <= er_idx_q + 1'b1;
               end
            end
            ppp_pkg::ST_PROG, ppp_pkg::ST_FUSE: begin
               if (cnt_q == 16'(OP_CYCLES - 1) && !fifo_rv) begin
                  st_q <= ppp_pkg::ST_IDLE;
               end else if (cnt_q != 16'(OP_CYCLES - 1)) begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
         endcase
      end
   end

   // Page buffer: drained from FIFO, refilled with erased words
   // outside the mode, on a no-op command and after each page commit
   logic no_op;
   logic commit;
   assign no_op  = act && {asel1, asel0} == `ACT_CMD && dat == `CMD_NOP;
   assign commit = st_q == ppp_pkg::ST_PROG &&
                   cnt_q == 16'(OP_CYCLES - 1) && !fifo_rv;
   always_ff @(posedge clock_in) begin
      if (enable_in) begin
         if (!mode_q || no_op || commit) begin
            for (int i = 0; i < PWORDS; i++) begin
               pbuf_q[i] <= {`ERASED_BYTE, `ERASED_BYTE};
            end
         end else if (fifo_rv) begin
            pbuf_q[fifo_rd[PAGE_BITS+15:16]] <= fifo_rd[15:0];
         end
      end
   end

   // Array writes: erase and page commit
   logic [FW-1:0]    page_base;
   logic [EE_AW-1:0] ee_base;
   assign page_base = word_addr(addr_hi_q, addr_lo_q) &
                      ~FW'(PWORDS - 1);
   assign ee_base = EE_AW'(addr_lo_q) & ~EE_AW'((1 << EE_PBITS) - 1);
   always_ff @(posedge clock_in) begin
      if (enable_in) begin
         if (st_q == ppp_pkg::ST_ERASE &&
             er_idx_q < (FW+1)'(FWORDS)) begin
            flash_q[er_idx_q[FW-1:0]] <=
               {`ERASED_BYTE, `ERASED_BYTE};
            if (er_idx_q < (FW+1)'(EBYTES) && fuse_hi_q[`KEEP_EE_BIT]) begin
               ee_q[er_idx_q[EE_AW-1:0]] <= `ERASED_BYTE;
            end
         end else if (commit) begin
            if (op_cmd_q == `CMD_WR_FLASH) begin
               for (int i = 0; i < PWORDS; i++) begin
                  flash_q[page_base | FW'(i)] <= pbuf_q[i];
               end
            end else begin
               for (int i = 0; i < (1 << EE_PBITS); i++) begin
                  ee_q[ee_base | EE_AW'(i)] <= pbuf_q[i][7:0];
               end
            end
         end
      end
   end

   // Fuse and lock bits; locks released only at erase end and on reset
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         lock_q    <= `LOCK_RESET;
         fuse_lo_q <= `FUSE_LO_RESET;
         fuse_hi_q <= `FUSE_HI_RESET;
         fuse_ex_q <= `FUSE_EX_RESET;
      end else if (enable_in) begin
         if (st_q == ppp_pkg::ST_ERASE &&
             er_idx_q == (FW+1)'(FWORDS)) begin
            lock_q <= `LOCK_RESET;
         end else if (st_q == ppp_pkg::ST_FUSE &&
                      cnt_q == 16'(OP_CYCLES - 1)) begin
            if (op_cmd_q == `CMD_WR_LOCK) begin
               lock_q <= lock_q & data_lo_q;
            end else if (bsel && !bsel2) begin
               fuse_hi_q <= data_lo_q;
            end else if (!bsel && bsel2) begin
               fuse_ex_q <= data_lo_q;
            end else begin
               fuse_lo_q <= data_lo_q;
            end
         end
      end
   end

   // Read path, registered
   logic [FW-1:0] ra;
   assign ra = word_addr(addr_hi_q, addr_lo_q);
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         data_out      <= 8'h00;
         data_oe_n_out <= 1'b1;
      end else if (enable_in) begin
         data_oe_n_out <= !(mode_q && !oe_n);
         unique case (cmd_q)
            `CMD_RD_FLASH:  data_out <= bsel ? flash_q[ra][15:8] :
                                              flash_q[ra][7:0];
            `CMD_RD_EEPROM: data_out <= ee_q[addr_lo_q];
            `CMD_RD_FUSE: begin
               unique case ({bsel2, bsel})
                  2'h0: data_out <= fuse_lo_q;
                  2'h3: data_out <= fuse_hi_q;
                  2'h2: data_out <= fuse_ex_q;
                  2'h1: data_out <= lock_q;
               endcase
            end
            `CMD_RD_SIG: begin
               if (bsel) data_out <= `CAL_BYTE;
               else if (addr_lo_q == 8'h00) data_out <= `SIG_BYTE_0;
               else if (addr_lo_q == 8'h01) data_out <= `SIG_BYTE_1;
               else data_out <= `SIG_BYTE_2;
            end
            default: data_out <= 8'h00;
         endcase
      end
   end
endmodule

//--- ppp_port_chk.sv
`timescale 1ns/1ps
module ppp_port_chk #(
   parameter int OP_CYCLES = 64
) (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic hv_reset_in,
   input wire logic write_strobe_n_in,
   input wire logic output_enable_n_in,
   input wire logic byte_select_lo_in,
   input wire logic action_sel_0_in,
   input wire logic action_sel_1_in,
   input wire logic data_oe_n_out,
   input wire logic ready_busy_n_out,
   input wire logic prog_mode_out
);
   logic [9:0]  ent_q;
   logic [13:0] busy_q;
   logic [2:0]  oe_hi_q;
   logic [3:0]  wr_q;

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (reset_in);

   // Cycles spent with high voltage and the all-zero entry pattern
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         ent_q <= '0;
      end else if (!hv_reset_in || write_strobe_n_in || byte_select_lo_in
                   || action_sel_0_in || action_sel_1_in) begin
         ent_q <= '0;
      end else if (ent_q != 10'h3FF) begin
         ent_q <= ent_q + 10'h001;
      end
   end

   // Length of the current busy stretch
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         busy_q <= '0;
      end else if (ready_busy_n_out) begin
         busy_q <= '0;
      end else if (busy_q != 14'h3FFF) begin
         busy_q <= busy_q + 14'h0001;
      end
   end

   // Cycles since the output enable pin went high
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         oe_hi_q <= '0;
      end else if (!output_enable_n_in) begin
         oe_hi_q <= '0;
      end else if (oe_hi_q != 3'h7) begin
         oe_hi_q <= oe_hi_q + 3'h1;
      end
   end

   // Cycles since the write pin went low
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         wr_q <= '0;
      end else if (write_strobe_n_in) begin
         wr_q <= '0;
      end else if (wr_q != 4'hF) begin
         wr_q <= wr_q + 4'h1;
      end
   end

   a_oe_release: assert property (
      !data_oe_n_out |-> prog_mode_out && oe_hi_q < 3'h6)
      else $error("bus driven without output enable");
   a_oe_drive: assert property (
      (prog_mode_out && !output_enable_n_in)[*6] |-> !data_oe_n_out)
      else $error("bus not driven while enabled");
   a_idle_no_drive: assert property (
      !prog_mode_out |-> data_oe_n_out)
      else $error("bus driven outside programming mode");
   a_mode_exit: assert property (
      !hv_reset_in [*5] |-> !prog_mode_out)
      else $error("mode kept without high voltage");
   a_mode_entry: assert property (
      $rose(prog_mode_out) |-> ent_q >= 10'h190)
      else $error("mode entered before pattern held");
   a_busy_cause: assert property (
      $fell(ready_busy_n_out) |-> !write_strobe_n_in && wr_q <= 4'h8)
      else $error("busy without write pulse");
   a_busy_min: assert property (
      $rose(ready_busy_n_out) |-> busy_q >= OP_CYCLES - 2)
      else $error("busy stretch too short");
   a_busy_bound: assert property (
      busy_q <= 14'h2010)
      else $error("busy stretch too long");

   c_entry: cover property ($rose(prog_mode_out));
   c_busy: cover property ($fell(ready_busy_n_out));
   c_drive: cover property ($fell(data_oe_n_out));
endmodule

bind ppp_port ppp_port_chk #(.OP_CYCLES(OP_CYCLES)) u_chk (.*);

//--- ppp_prog.sv
`timescale 1ns/1ps
module ppp_prog (
   input  wire logic       clock_in,
   input  wire logic       ready_busy_n_in,
   input  wire logic       data_oe_n_in,
   input  wire logic [7:0] bus_in,
   output logic            hv_out,
   output logic            clk_out,
   output logic            wr_n_out,
   output logic            oe_n_out,
   output logic            bsel_out,
   output logic            asel0_out,
   output logic            asel1_out,
   output logic      [7:0] data_out
);
   // Pins idle at the entry pattern
   initial begin
      {hv_out, clk_out, wr_n_out, bsel_out, asel0_out, asel1_out} = 6'h00;
      oe_n_out = 1'b1;
      data_out = 8'h00;
   end

   // Wait n edges, then move just after the edge
   task automatic step(input int n);
      repeat (n) @(posedge clock_in);
      #2;
   endtask

   // Raise high voltage, hold pattern, wait before commands
   task automatic enter();
      hv_out = 1'b1;
      step(12000);
      wr_n_out = 1'b1;
      step(20);
   endtask

   // Drop high voltage
   task automatic leave();
      hv_out = 1'b0;
      step(10);
   endtask

   // One load strobe pulse with action and byte select
   task automatic load(input logic [1:0] a, input logic b,
                       input logic [7:0] d);
      {asel1_out, asel0_out} = a;
      bsel_out = b;
      data_out = d;
      step(4);
      clk_out = 1'b1;
      step(12);
      clk_out = 1'b0;
      step(12);
   endtask

   // Page latch pulse on the byte select pin
   task automatic latch();
      {asel1_out, asel0_out} = 2'h3;
      bsel_out = 1'b0;
      step(4);
      bsel_out = 1'b1;
      step(12);
      bsel_out = 1'b0;
      step(12);
   endtask

   // Negative write pulse
   task automatic wr_pulse(input logic b);
      bsel_out = b;
      step(4);
      wr_n_out = 1'b0;
      step(12);
      wr_n_out = 1'b1;
      step(4);
   endtask

   // Bounded wait for ready
   task automatic wait_ready();
      int i;
      i = 0;
      while (ready_busy_n_in !== 1'b1 && i < 9000) begin
         step(1);
         i++;
      end
   endtask

   // Invert the driven data, enable output, sample
   task automatic read(input logic b1, input logic b2,
                       output logic [7:0] v, output logic o);
      bsel_out = b1;
      asel1_out = b2;
      data_out = ~data_out;
      oe_n_out = 1'b0;
      step(10);
      v = bus_in;
      o = data_oe_n_in;
      oe_n_out = 1'b1;
      step(6);
   endtask
endmodule

//--- parallel_programming_port_tb.sv
`timescale 1ns/1ps
`include "ppp_cfg.svh"
module parallel_programming_port_tb;
   logic       clock_in, reset_in, hv, ldclk, wr_n, oe_n, bsel, asel0, asel1;
   logic       oe_n_o, rb_n, pm, o;
   logic [7:0] pd, dout, bus, v;
   int         err_total = 0;
   int         total_checks = 0;
   int         cyc = 0;
   logic [7:0] sig [3] = '{`SIG_BYTE_0, `SIG_BYTE_1, `SIG_BYTE_2};

   // Shared data bus
   assign bus = oe_n_o ? pd : dout;

   ppp_port #(.OP_CYCLES(32)) u_dut (
      .clock_in(clock_in), .reset_in(reset_in), .enable_in(1'b1),
      .hv_reset_in(hv), .load_strobe_clock_in(ldclk),
      .write_strobe_n_in(wr_n), .output_enable_n_in(oe_n),
      .byte_select_lo_in(bsel), .action_sel_0_in(asel0),
      .action_sel_1_in(asel1), .data_in(bus), .data_out(dout),
      .data_oe_n_out(oe_n_o), .ready_busy_n_out(rb_n),
      .prog_mode_out(pm));

   ppp_prog u_prog (
      .clock_in(clock_in), .ready_busy_n_in(rb_n), .data_oe_n_in(oe_n_o),
      .bus_in(bus), .hv_out(hv), .clk_out(ldclk), .wr_n_out(wr_n),
      .oe_n_out(oe_n), .bsel_out(bsel), .asel0_out(asel0),
      .asel1_out(asel1),
      .data_out(pd));

   // Clock
   initial begin
      clock_in = 1'b0;
      forever #12.5 clock_in = ~clock_in;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         stop_test();
      end
   end

   // Test sequence
   initial begin
      reset_in = 1'b1;
      repeat (5) @(posedge clock_in);
      #2 reset_in = 1'b0;
      check({7'h00, oe_n_o}, 8'h01);
      check({7'h00, rb_n}, 8'h01);
      check({7'h00, pm}, 8'h00);
      $display("test reset done");
      u_prog.enter();
      check({7'h00, pm}, 8'h01);
      $display("test entry done");
      u_prog.load(2'h2, 1'b0, `CMD_CHIP_ERASE);
      u_prog.wr_pulse(1'b0);
      check({7'h00, rb_n}, 8'h00);
      u_prog.wait_ready();
      check({7'h00, rb_n}, 8'h01);
      $display("test erase done");
      u_prog.load(2'h2, 1'b0, `CMD_WR_FLASH);
      for (int i = 0; i < 2; i++) begin
         u_prog.load(2'h0, 1'b0, 8'h13 + 8'(i));
         u_prog.load(2'h1, 1'b0, 8'hC0 + 8'(i));
         u_prog.load(2'h1, 1'b1, 8'h30 + 8'(i));
         u_prog.latch();
      end
      u_prog.load(2'h0, 1'b1, 8'h02);
      u_prog.wr_pulse(1'b0);
      check({7'h00, rb_n}, 8'h00);
      u_prog.wait_ready();
      check({7'h00, rb_n}, 8'h01);
      u_prog.load(2'h2, 1'b0, `CMD_NOP);
      $display("test program done");
      u_prog.load(2'h2, 1'b0, `CMD_RD_FLASH);
      u_prog.load(2'h0, 1'b1, 8'h02);
      for (int i = 0; i < 4; i++) begin
         u_prog.load(2'h0, 1'b0, (i < 3) ? 8'h13 + 8'(i) : 8'h03);
         u_prog.read(1'b0, 1'b0, v, o);
         check(v, (i < 2) ? 8'hC0 + 8'(i) : 8'hFF);
         check({7'h00, o}, 8'h00);
         u_prog.read(1'b1, 1'b0, v, o);
         check(v, (i < 2) ? 8'h30 + 8'(i) : 8'hFF);
      end
      $display("test flash read done");
      u_prog.load(2'h2, 1'b0, `CMD_RD_SIG);
      u_prog.load(2'h0, 1'b0, 8'h00);
      u_prog.load(2'h3, 1'b0, 8'h55);
      u_prog.read(1'b0, 1'b0, v, o);
      check(v, sig[0]);
      u_prog.read(1'b1, 1'b0, v, o);
      check(v, `CAL_BYTE);
      for (int i = 0; i < 3; i++) begin
         u_prog.load(2'h0, 1'b0, 8'(i));
         u_prog.read(1'b0, 1'b0, v, o);
         check(v, sig[i]);
      end
      $display("test signature done");
      u_prog.load(2'h2, 1'b0, `CMD_RD_FUSE);
      u_prog.read(1'b0, 1'b0, v, o);
      check(v, `FUSE_LO_RESET);
      u_prog.read(1'b1, 1'b1, v, o);
      check(v, `FUSE_HI_RESET);
      u_prog.read(1'b0, 1'b1, v, o);
      check(v, `FUSE_EX_RESET);
      u_prog.read(1'b1, 1'b0, v, o);
      check(v, `LOCK_RESET);
      $display("test fuse read done");
      u_prog.leave();
      check({7'h00, pm}, 8'h00);
      u_prog.read(1'b0, 1'b0, v, o);
      check({7'h00, o}, 8'h01);
      $display("test exit done");
      stop_test();
   end
endmodule
